// ### include/fscr_pkg.sv
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package fscr_pkg;

    // ----------------------------------------------------------------
    // instruction codes
    // ----------------------------------------------------------------
    localparam logic [7:0] CMD_WRITE_ENABLE = 8'h06;
    localparam logic [7:0] CMD_WRITE_DISABLE = 8'h04;
    localparam logic [7:0] CMD_READ_STATUS = 8'h05;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [7:0] CMD_READ_CONFIG = 8'h35;
    localparam logic [7:0] CMD_QUAD_OUT_READ = 8'h6b;
    localparam logic [7:0] CMD_QUAD_IO_READ = 8'heb;
    localparam logic [7:0] CMD_WRAP_BURST_READ = 8'hec;
    localparam logic [7:0] CMD_QUAD_PAGE_PROG = 8'h32;

    // ----------------------------------------------------------------
    // status field positions
    // ----------------------------------------------------------------
    localparam int ST_BUSY_LO = 0;
    localparam int ST_WEL = 1;
    localparam int ST_ERASE_SUSP = 2;
    localparam int ST_PROG_SUSP = 3;
    localparam int ST_LOCKDOWN = 4;
    localparam int ST_SEC_LOCK = 5;
    localparam int ST_BUSY_HI = 7;

    // ----------------------------------------------------------------
    // configuration field positions and reset values
    // ----------------------------------------------------------------
    localparam int CF_PIN_ROLE = 1;
    localparam int CF_PERM_LOCK = 3;
    localparam int CF_PROT_EN = 7;
    localparam logic RST_PIN_ROLE = 1'b0;
    localparam logic RST_PERM_LOCK = 1'b1;
    localparam logic RST_PROT_EN = 1'b0;
    localparam logic [7:0] RST_BYTE = 8'h00;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 5;
    localparam int PROT_EN_WRITE_TIME_NS = 10000;
    localparam int PROT_EN_WRITE_CYC_RAW = PROT_EN_WRITE_TIME_NS / CLK_PERIOD_NS;
    localparam int PROT_EN_WRITE_CYC = (PROT_EN_WRITE_CYC_RAW < 1) ? 1 : PROT_EN_WRITE_CYC_RAW;
    localparam int TIMER_W = 12;

    typedef enum logic [1:0] {
        FSCR_CMD = 2'b00,
        FSCR_WRSR = 2'b01,
        FSCR_READ = 2'b10,
        FSCR_SKIP = 2'b11
    } fscr_phase_e;

    // events from the instruction engine, all one-cycle pulses
    typedef struct packed {
        logic soft_reset;
        logic write_suspend;
        logic bp_write;
        logic lockdown;
        logic op_done;
        logic sid_lockout_done;
        logic nv_lock_set;
        logic resume;
    } fscr_events_s;

    // engine levels
    typedef struct packed {
        logic erase_running;
        logic prog_running;
        logic four_lane_mode;
    } fscr_core_s;

    // values held in nonvolatile cells, read once after reset
    typedef struct packed {
        logic prot_en;
        logic sec_lock;
        logic lock_any;
    } fscr_nv_s;

endpackage

// ### src/fscr_regs.sv
`timescale 1ns/1ps
module fscr_regs (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // serial pins
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic i_wp_n,
    output logic o_so,
    output logic o_so_oe,
    // instruction engine
    input wire fscr_pkg::fscr_events_s i_evt,
    input wire fscr_pkg::fscr_core_s i_core,
    input wire logic i_suspend,
    // nonvolatile storage
    input wire fscr_pkg::fscr_nv_s i_nv,
    output logic o_nv_prot_en_wr,
    output logic o_nv_prot_en_data,
    // status towards the engine
    output logic o_write_enabled,
    output logic o_busy,
    output logic o_hw_protect,
    output logic o_quad_pins,
    output logic o_hold_enable,
    output logic o_invalid_cmd,
    output logic [7:0] o_status,
    output logic [7:0] o_config
);
    import fscr_pkg::*;

    typedef struct packed {
        logic sck1;
        logic sck2;
        logic sck_d;
        logic cs1;
        logic cs2;
        logic cs_d;
        logic si1;
        logic si2;
        logic wp1;
        logic wp2;
        fscr_phase_e phase;
        logic [7:0] shreg;
        logic [2:0] bitcnt;
        logic [1:0] nbytes;
        logic [7:0] cfg_in;
        logic rd_cfg;
        logic [7:0] tx;
        logic so;
        logic so_oe;
        logic loaded;
        logic write_enable_latch;
        logic erase_susp;
        logic prog_susp;
        logic lockdown;
        logic sec_lock;
        logic pin_role;
        logic perm_lock;
        logic prot_en;
        logic [TIMER_W-1:0] timer;
        logic nv_wr;
        logic busy;
        logic hw_prot;
        logic hold;
        logic invalid;
        logic [7:0] status;
        logic [7:0] config_b;
    } fscr_state_s;

    fscr_state_s r;
    fscr_state_s n;

    // ----------------------------------------------------------------
    // byte images
    // ----------------------------------------------------------------
    function automatic logic [7:0] fscr_status_byte(input fscr_state_s s);
        logic [7:0] b;
        b = RST_BYTE;
        b[ST_BUSY_LO] = s.busy;
        b[ST_BUSY_HI] = s.busy;
        b[ST_WEL] = s.write_enable_latch;
        b[ST_ERASE_SUSP] = s.erase_susp;
        b[ST_PROG_SUSP] = s.prog_susp;
        b[ST_LOCKDOWN] = s.lockdown;
        b[ST_SEC_LOCK] = s.sec_lock;
        return b;
    endfunction

    function automatic logic [7:0] fscr_config_byte(input fscr_state_s s);
        logic [7:0] b;
        b = RST_BYTE; // reserved bits read zero
        b[CF_PIN_ROLE] = s.pin_role;
        b[CF_PERM_LOCK] = s.perm_lock;
        b[CF_PROT_EN] = s.prot_en;
        return b;
    endfunction

    // ----------------------------------------------------------------
    // instruction decode
    // ----------------------------------------------------------------
    function automatic logic fscr_is_quad_cmd(input logic [7:0] c);
        return (c == CMD_QUAD_OUT_READ) || (c == CMD_QUAD_IO_READ) ||
               (c == CMD_WRAP_BURST_READ) || (c == CMD_QUAD_PAGE_PROG);
    endfunction

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        logic sck_rise;
        logic sck_fall;
        logic cs_rise;
        logic selected;
        logic [7:0] rx;
        logic [7:0] img;
        logic busy_now;
        sck_rise = 1'b0;
        sck_fall = 1'b0;
        cs_rise = 1'b0;
        selected = 1'b0;
        rx = RST_BYTE;
        img = RST_BYTE;
        busy_now = 1'b0;
        n = r;

        // ----------------------------------------------------------------
        // pin synchronisers and edge detect
        // ----------------------------------------------------------------
        // pins pass two flops before any use
        n.sck1 = i_sck;
        n.sck2 = r.sck1;
        n.sck_d = r.sck2;
        n.cs1 = i_cs_n;
        n.cs2 = r.cs1;
        n.cs_d = r.cs2;
        n.si1 = i_si;
        n.si2 = r.si1;
        n.wp1 = i_wp_n;
        n.wp2 = r.wp1;
        sck_rise = r.sck2 & ~r.sck_d;
        sck_fall = ~r.sck2 & r.sck_d;
        cs_rise = r.cs2 & ~r.cs_d;
        // single-lane decode only; four-lane traffic belongs to the engine
        selected = ~r.cs2 & ~i_core.four_lane_mode;
        rx = {r.shreg[6:0], r.si2};
        busy_now = i_core.erase_running | i_core.prog_running | (r.timer != '0);

        // ----------------------------------------------------------------
        // pulses and the protect enable write timer
        // ----------------------------------------------------------------
        // both pulses fall back on their own after one cycle
        n.nv_wr = 1'b0;
        n.invalid = 1'b0;
        if (r.timer != '0) begin
            n.timer = r.timer - 1'b1;
        end

        // ----------------------------------------------------------------
        // nonvolatile load
        // ----------------------------------------------------------------
        // nonvolatile values are picked up on the first edge after release;
        // an event in that same cycle is applied below and wins over the load
        if (!r.loaded) begin
            n.loaded = 1'b1;
            n.prot_en = i_nv.prot_en;
            n.sec_lock = i_nv.sec_lock;
            n.perm_lock = ~i_nv.lock_any;
        end

        // ----------------------------------------------------------------
        // engine events: clears first so that a set in the same cycle wins
        // ----------------------------------------------------------------
        if (i_evt.soft_reset || i_evt.write_suspend || i_evt.bp_write ||
            i_evt.lockdown || i_evt.op_done) begin
            n.write_enable_latch = 1'b0;
        end

        // ----------------------------------------------------------------
        // suspend flags
        // ----------------------------------------------------------------
        if (i_evt.resume) begin
            // a program suspended inside a suspended erase resumes first
            if (r.prog_susp) begin
                n.prog_susp = 1'b0;
            end else begin
                n.erase_susp = 1'b0;
            end
        end
        if (i_suspend && i_core.erase_running) begin
            n.erase_susp = 1'b1;
        end
        if (i_suspend && i_core.prog_running) begin
            n.prog_susp = 1'b1;
        end

        // ----------------------------------------------------------------
        // sticky lock flags
        // ----------------------------------------------------------------
        if (i_evt.lockdown) begin
            n.lockdown = 1'b1; // only reset clears it
        end
        if (i_evt.sid_lockout_done) begin
            n.sec_lock = 1'b1; // only reset clears it, and the load after reset restores the stored value
        end
        if (i_evt.nv_lock_set) begin
            n.perm_lock = 1'b0;
        end

        // ----------------------------------------------------------------
        // serial register access, mode 0
        // ----------------------------------------------------------------
        if (!selected) begin
            // config is committed only as the frame closes, so a frame cut short
            // before the second data byte leaves everything untouched
            if (cs_rise && r.phase == FSCR_WRSR && r.nbytes == 2'd2) begin
                if (r.write_enable_latch && !busy_now) begin
                    n.write_enable_latch = 1'b0;
                    if (!r.hw_prot) begin
                        n.pin_role = r.cfg_in[CF_PIN_ROLE];
                        if (r.cfg_in[CF_PROT_EN] != r.prot_en) begin
                            n.prot_en = r.cfg_in[CF_PROT_EN];
                            n.nv_wr = 1'b1;
                            n.timer = TIMER_W'(PROT_EN_WRITE_CYC);
                        end
                    end
                end
            end
            n.phase = FSCR_CMD;
            n.bitcnt = '0;
            n.nbytes = '0;
            n.so_oe = 1'b0;
            n.so = 1'b0;
        end else if (sck_rise) begin
            // shift one bit in; act once a whole byte has arrived
            n.shreg = rx;
            n.bitcnt = r.bitcnt + 1'b1;
            if (r.bitcnt == 3'd7) begin
                unique case (r.phase)
                    FSCR_CMD: begin
                        n.phase = FSCR_SKIP;
                        if (rx == CMD_WRITE_ENABLE) begin
                            n.write_enable_latch = 1'b1;
                        end else if (rx == CMD_WRITE_DISABLE) begin
                            n.write_enable_latch = 1'b0;
                        end else if (rx == CMD_READ_STATUS) begin
                            n.phase = FSCR_READ;
                            n.rd_cfg = 1'b0;
                        end else if (rx == CMD_READ_CONFIG) begin
                            n.phase = FSCR_READ;
                            n.rd_cfg = 1'b1;
                        end else if (rx == CMD_WRITE_STATUS) begin
                            n.phase = FSCR_WRSR;
                        end else if (fscr_is_quad_cmd(rx) && !r.pin_role) begin
                            n.invalid = 1'b1;
                        end
                    end
                    FSCR_WRSR: begin
                        // first byte is the read-only status image
                        if (r.nbytes == 2'd1) begin
                            n.cfg_in = rx;
                        end
                        if (r.nbytes != 2'd2) begin
                            n.nbytes = r.nbytes + 1'b1;
                        end
                    end
                    FSCR_READ: begin
                    end
                    FSCR_SKIP: begin
                    end
                endcase
            end
        end else if (sck_fall && r.phase == FSCR_READ) begin
            // launched after the fall so the host finds a settled bit at the rise
            if (r.bitcnt == 3'd0) begin
                // fresh image per byte so polling sees busy drop
                img = r.rd_cfg ? fscr_config_byte(r) : fscr_status_byte(r);
                n.so = img[7];
                n.tx = {img[6:0], 1'b0};
            end else begin
                n.so = r.tx[7];
                n.tx = {r.tx[6:0], 1'b0};
            end
            n.so_oe = 1'b1;
        end

        // ----------------------------------------------------------------
        // derived outputs, registered with the rest
        // ----------------------------------------------------------------
        // busy also covers the protect enable write so polling sees it finish
        n.busy = i_core.erase_running | i_core.prog_running | (n.timer != '0);
        // pin role wins over the enable bit
        // the pin is read from the second flop only; the first may still be settling
        n.hw_prot = ~r.wp2 & n.prot_en & ~n.pin_role;
        // hold pauses only while the pins keep their single-lane roles
        n.hold = ~n.pin_role & ~i_core.four_lane_mode;
        n.status = fscr_status_byte(n);
        n.config_b = fscr_config_byte(n);
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // sync chains start at the idle level of their pins: no false edge
            r <= '0;
            r.sck1 <= 1'b0;
            r.cs1 <= 1'b1;
            r.cs2 <= 1'b1;
            r.cs_d <= 1'b1;
            r.wp1 <= 1'b1;
            r.wp2 <= 1'b1;
            r.hold <= 1'b1;
            r.phase <= FSCR_CMD;
            r.pin_role <= RST_PIN_ROLE;
            r.perm_lock <= RST_PERM_LOCK;
            r.prot_en <= RST_PROT_EN;
            r.config_b <= {RST_PROT_EN, 3'b000, RST_PERM_LOCK, 1'b0, RST_PIN_ROLE, 1'b0};
        end else begin
            r <= n;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // serial pins
    assign o_so = r.so;
    assign o_so_oe = r.so_oe;
    // nonvolatile write
    assign o_nv_prot_en_wr = r.nv_wr;
    assign o_nv_prot_en_data = r.prot_en;
    // engine side
    assign o_write_enabled = r.write_enable_latch; // engine rejects writes while low
    assign o_busy = r.busy;
    assign o_hw_protect = r.hw_prot;
    assign o_quad_pins = r.pin_role;
    assign o_hold_enable = r.hold;
    assign o_invalid_cmd = r.invalid;
    // register images
    assign o_status = r.status;
    assign o_config = r.config_b;

endmodule

// ### test/fscr_host_model.sv
`timescale 1ns/1ps
module fscr_host_model (
    // serial pins towards the device
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b1;
    end

    // one frame, mode 0, msb first; rx keeps the last eight bits read
    task automatic frame(input logic [23:0] tx, input int nb, output logic [7:0] rx);
        rx = 8'h00;
        o_cs_n = 1'b0;
        #80;
        for (int i = 0; i < nb * 8; i++) begin
            o_si = tx[23-i];
            #80 o_sck = 1'b1;
            rx = {rx[6:0], i_so};
            #80 o_sck = 1'b0;
        end
        #80 o_cs_n = 1'b1;
        // released line shows the inverse so a stale bit cannot pass
        o_si = ~o_si;
        #320;
    endtask
endmodule

// ### test/fscr_regs_assertions.sv
`timescale 1ns/1ps
module fscr_regs_checker (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_rst_n,
    // engine side
    input wire fscr_pkg::fscr_events_s i_evt,
    input wire fscr_pkg::fscr_core_s i_core,
    input wire logic i_suspend,
    // observed outputs
    input wire logic o_busy,
    input wire logic o_write_enabled,
    input wire logic o_hw_protect,
    input wire logic o_quad_pins,
    input wire logic o_hold_enable,
    input wire logic o_nv_prot_en_wr,
    input wire logic [7:0] o_status,
    input wire logic [7:0] o_config
);
    import fscr_pkg::*;
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    // ----------------------------------------------------------------
    // register images
    // ----------------------------------------------------------------
    a_status_layout: assert property (o_status[0] == o_status[7] && !o_status[6])
        else $error("status byte layout broken");
    a_config_reserved: assert property ((o_config & 8'h75) == 8'h00)
        else $error("reserved config bit set");
    // hold is registered, so it follows the lane mode seen one edge earlier
    a_hold_pins: assert property (o_hold_enable ==
        (!o_quad_pins && !$past(i_core.four_lane_mode)))
        else $error("hold enable wrong");
    // config held two cycles; the registered protect output changes in the same cycle as the config image
    a_hw_protect: assert property (o_hw_protect && o_config == $past(o_config, 2)
        |-> o_config[7] && !o_config[1])
        else $error("hardware protect without its enables");

    // ----------------------------------------------------------------
    // flags
    // ----------------------------------------------------------------
    a_wel_clear: assert property ((i_evt[7:3] != 5'h00) |=> !o_write_enabled)
        else $error("latch kept after clearing event");
    a_erase_susp: assert property (i_suspend && i_core.erase_running |=> o_status[2])
        else $error("erase suspend flag not set");
    a_prog_susp: assert property (i_suspend && i_core.prog_running |=> o_status[3])
        else $error("program suspend flag not set");
    a_busy_run: assert property (i_core.erase_running || i_core.prog_running |=> o_busy)
        else $error("busy low during operation");
    a_lockdown_hold: assert property (i_evt.lockdown || o_status[4] |=> o_status[4])
        else $error("lock-down flag dropped");
    a_sec_hold: assert property (i_evt.sid_lockout_done || o_status[5] |=> o_status[5])
        else $error("security lock flag dropped");
    a_perm_hold: assert property (i_evt.nv_lock_set || !o_config[3] |=> !o_config[3])
        else $error("permanent lock state came back");
    a_prot_busy: assert property (o_nv_prot_en_wr |-> ##[0:2] o_busy[*8])
        else $error("protect enable write not busy");

    c_erase_susp: cover property (i_suspend && i_core.erase_running);
    c_prot_write: cover property (o_nv_prot_en_wr);
    c_hw_protect: cover property (o_hw_protect);
endmodule

// ### test/fscr_regs_test.sv
`timescale 1ns/1ps
module fscr_regs_test;
    import fscr_pkg::*;
    logic i_mclk = 1'b0;
    logic i_rst_n, i_wp_n, i_suspend;
    fscr_events_s i_evt;
    fscr_core_s i_core;
    fscr_nv_s i_nv;
    logic sck, cs_n, si, so, so_oe, nv_wr, nv_data, write_enable_latch, busy, hwp, quad, hold, inv;
    logic [7:0] status, config_img;
    int num_errors, total_checks;
    int n_inv = 0;

    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (inv === 1'b1) n_inv <= n_inv + 1;

    fscr_host_model i_fscr_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so));
    fscr_regs i_fscr_regs (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .i_wp_n(i_wp_n), .o_so(so), .o_so_oe(so_oe), .i_evt(i_evt),
        .i_core(i_core), .i_suspend(i_suspend), .i_nv(i_nv), .o_nv_prot_en_wr(nv_wr),
        .o_nv_prot_en_data(nv_data), .o_write_enabled(write_enable_latch), .o_busy(busy),
        .o_hw_protect(hwp), .o_quad_pins(quad), .o_hold_enable(hold),
        .o_invalid_cmd(inv), .o_status(status), .o_config(config_img));

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask
    task automatic xf(input logic [23:0] tx, input int nb, output logic [7:0] v);
        i_fscr_host_model.frame(tx, nb, v);
        step(1);
    endtask
    task automatic wren();
        logic [7:0] v;
        xf({CMD_WRITE_ENABLE, 16'h0000}, 1, v);
    endtask
    task automatic wrsr(input logic [7:0] cfg);
        logic [7:0] v;
        wren();
        xf({CMD_WRITE_STATUS, 8'h00, cfg}, 3, v);
    endtask
    task automatic pulse(input fscr_events_s e, input logic s);
        step(1);
        i_evt = e;
        i_suspend = s;
        step(1);
        i_evt = '0;
        i_suspend = 1'b0;
        step(2);
    endtask
    task automatic do_reset(input fscr_nv_s nv);
        step(1);
        i_rst_n = 1'b0;
        i_nv = nv;
        step(6);
        i_rst_n = 1'b1;
        step(4);
    endtask
    task automatic wait_idle();
        int c;
        c = 0;
        while (busy !== 1'b0 && c < 3000) begin
            step(1);
            c++;
        end
        if (c == 3000) begin
            num_errors++;
            summarize();
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_power_up();
        chk(status, 8'h00);
        chk(config_img, 8'h08);
        chk(hold, 1'b1);
        do_reset(3'b111);
        chk(status, 8'h20);
        chk(config_img, 8'h80);
        do_reset(3'b000);
        chk(config_img, 8'h08);
        $display("power-up test done");
    endtask
    task automatic t_latch();
        logic [7:0] v;
        fscr_events_s e;
        wren();
        xf({CMD_READ_STATUS, 16'h0000}, 2, v);
        chk(v, 8'h02);
        xf({CMD_WRITE_DISABLE, 16'h0000}, 1, v);
        chk(write_enable_latch, 1'b0);
        for (int k = 3; k < 8; k++) begin
            wren();
            chk(write_enable_latch, 1'b1);
            e = '0;
            e[k] = 1'b1;
            pulse(e, 1'b0);
            chk(write_enable_latch, 1'b0);
        end
        $display("latch test done");
    endtask
    task automatic t_suspend();
        logic [7:0] v;
        for (int j = 0; j < 2; j++) begin
            i_core = j ? 3'b010 : 3'b100;
            step(3);
            xf({CMD_READ_STATUS, 16'h0000}, 2, v);
            chk(v, 8'h91);
            pulse('0, 1'b1);
            i_core = '0;
            step(2);
            chk(status, j ? 8'h18 : 8'h14);
            pulse(8'h01, 1'b0);
            chk(status, 8'h10);
        end
        $display("suspend test done");
    endtask
    task automatic t_quad(input logic [7:0] exp);
        logic [7:0] v;
        logic [7:0] q [4];
        int n0;
        q = '{CMD_QUAD_OUT_READ, CMD_QUAD_IO_READ, CMD_WRAP_BURST_READ, CMD_QUAD_PAGE_PROG};
        for (int k = 0; k < 4; k++) begin
            n0 = n_inv;
            xf({q[k], 16'h0000}, 1, v);
            chk(8'(n_inv - n0), exp);
        end
        $display("quad command test done");
    endtask
    task automatic t_config();
        logic [7:0] v;
        wrsr(8'h82);
        chk(config_img, 8'h8a);
        chk(busy, 1'b1);
        wait_idle();
        chk({quad, hold}, 8'h02);
        chk(nv_data, 1'b1);
        xf({CMD_READ_CONFIG, 16'h0000}, 2, v);
        chk(v, 8'h8a);
        chk(so_oe, 1'b0);
        i_wp_n = 1'b0;
        step(4);
        chk(hwp, 1'b0);
        t_quad(8'h00);
        wrsr(8'h80);
        step(2);
        chk(hwp, 1'b1);
        wrsr(8'h00);
        chk(config_img, 8'h88);
        chk(write_enable_latch, 1'b0);
        wren();
        chk(write_enable_latch, 1'b1);
        i_core = 3'b001;
        step(1);
        chk(hold, 1'b0);
        i_core = '0;
        i_wp_n = 1'b1;
        step(4);
        wrsr(8'h00);
        chk(config_img, 8'h08);
        wait_idle();
        $display("config test done");
    endtask
    task automatic t_sticky();
        pulse(8'h10, 1'b0);
        pulse(8'h04, 1'b0);
        pulse(8'h80, 1'b0);
        chk(status, 8'h30);
        pulse(8'h02, 1'b0);
        chk(config_img, 8'h00);
        do_reset(3'b011);
        chk(status, 8'h20);
        chk(config_img, 8'h00);
        $display("sticky flag test done");
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    initial begin
        i_rst_n = 1'b0;
        i_wp_n = 1'b1;
        i_suspend = 1'b0;
        i_evt = '0;
        i_core = '0;
        i_nv = '0;
        num_errors = 0;
        total_checks = 0;
        step(6);
        i_rst_n = 1'b1;
        step(4);
        t_power_up();
        t_latch();
        t_suspend();
        t_quad(8'h01);
        t_config();
        t_sticky();
        summarize();
    end
endmodule

bind fscr_regs fscr_regs_checker i_fscr_regs_checker (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_evt(i_evt), .i_core(i_core), .i_suspend(i_suspend), .o_busy(o_busy),
    .o_write_enabled(o_write_enabled), .o_hw_protect(o_hw_protect),
    .o_quad_pins(o_quad_pins), .o_hold_enable(o_hold_enable),
    .o_nv_prot_en_wr(o_nv_prot_en_wr), .o_status(o_status), .o_config(o_config));
